/* ddr_sram_pkg.sv */
// Shared constants for the burst SRAM port protocol block
package ddr_sram_pkg;

	// ------------------------------------------------------------
	// Array and data geometry
	// ------------------------------------------------------------
	localparam int ADDR_W        = 22;
	localparam int LANE_W        = 9;
	localparam int LANES_WORD    = 4;
	localparam int WORD_W        = LANE_W * LANES_WORD;
	localparam int LANES_BURST   = 2 * LANES_WORD;
	localparam int BURST_W       = 2 * WORD_W;
	localparam int NARROW_LANES  = 2;
	localparam int NARROW_ADDR_W = 22;
	localparam int WIDE_ADDR_W   = 21;

	// ------------------------------------------------------------
	// Read latency in input clock cycles
	// ------------------------------------------------------------
	localparam int READ_LAT_FULL   = 2;
	localparam int READ_LAT_LEGACY = 1;

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	localparam int          AXI_ADDR_W     = 8;
	localparam int          AXI_DATA_W     = 32;
	localparam int          RESP_W         = 2;
	localparam int          BUF_DEPTH      = 2;
	localparam logic [7:0]  OFS_CTRL       = 8'h00;
	localparam logic [7:0]  OFS_STATUS     = 8'h04;
	localparam logic [7:0]  OFS_RD_COUNT   = 8'h08;
	localparam logic [7:0]  OFS_WR_COUNT   = 8'h0c;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	localparam int          CTRL_NARROW    = 0;
	localparam int          CTRL_CLR_CNT   = 1;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
	localparam int          STAT_OE        = 0;
	localparam int          STAT_VALID     = 1;
	localparam int          STAT_LAT_FULL  = 2;
	localparam int          STAT_WR_ARMED  = 3;

	typedef enum logic {
		WR_IDLE  = 1'b0,
		WR_ARMED = 1'b1
	} wr_state_type;

endpackage

/* two_entry_buffer.sv */
// Two-entry valid/ready buffer for register read answers
`timescale 1ns/10ps
module two_entry_buffer #(
	parameter int WIDTH = 34
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	// Filling side
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	// Draining side
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic [WIDTH-1:0]      o_out_data
);
	import ddr_sram_pkg::*;

	logic [WIDTH-1:0] mem_q [BUF_DEPTH];
	logic [WIDTH-1:0] mem_d [BUF_DEPTH];
	logic             wr_ptr_q, wr_ptr_d;
	logic             rd_ptr_q, rd_ptr_d;
	logic [1:0]       count_q, count_d;
	logic             push, pop;

	assign o_in_ready  = (count_q != 2'h2);
	assign o_out_valid = (count_q != 2'h0);
	assign o_out_data  = mem_q[rd_ptr_q];

	always_comb begin
		push     = i_in_valid & o_in_ready;
		pop      = o_out_valid & i_out_ready;
		mem_d    = mem_q;
		wr_ptr_d = wr_ptr_q;
		rd_ptr_d = rd_ptr_q;
		count_d  = count_q;
		if (push) begin
			mem_d[wr_ptr_q] = i_in_data;
			wr_ptr_d        = ~wr_ptr_q;
		end
		if (pop) begin
			rd_ptr_d = ~rd_ptr_q;
		end
		if (push && !pop) begin
			count_d = count_q + 2'h1;
		end else if (pop && !push) begin
			count_d = count_q - 2'h1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mem_q    <= '{default: '0};
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			count_q  <= 2'h0;
		end else begin
			mem_q    <= mem_d;
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			count_q  <= count_d;
		end
	end

endmodule

/* burst_array.sv */
// Storage array: one two-word burst per location, written per lane
`timescale 1ns/10ps
module burst_array (
	// Clock
	input  wire logic                                    i_clk,
	// Write port
	input  wire logic                                    i_wr_en,
	input  wire logic [ddr_sram_pkg::ADDR_W-1:0]         i_wr_addr,
	input  wire logic [ddr_sram_pkg::LANES_BURST-1:0]    i_wr_lane_en,
	input  wire logic [ddr_sram_pkg::BURST_W-1:0]        i_wr_data,
	// Read port
	input  wire logic [ddr_sram_pkg::ADDR_W-1:0]         i_rd_addr,
	output logic [ddr_sram_pkg::BURST_W-1:0]             o_rd_data
);
	import ddr_sram_pkg::*;

	logic [BURST_W-1:0] store [2**ADDR_W];

	assign o_rd_data = store[i_rd_addr];

	// Lanes whose enable is low keep their contents
	always_ff @(posedge i_clk) begin
		for (int g = 0; g < LANES_BURST; g++) begin
			if (i_wr_en && i_wr_lane_en[g]) begin
				store[i_wr_addr][g*LANE_W +: LANE_W] <= i_wr_data[g*LANE_W +: LANE_W];
			end
		end
	end

endmodule

/* ddr_burst_sram_port_protocol.sv */
// Burst SRAM port protocol with register access over AXI4-Lite
//
// How it works
// - Read starts on read select low at a pos rise; address latched there.
// - Full latency: word one at pos rise t+2, word two at next neg rise.
// - Write starts on write select low at a pos rise; word one captured there.
// - Write address and word two are taken at that cycle's neg rise.
// - First word fills the low half, second the high half, of the one burst location at that address.
// - Cycle offsets count pos clock cycles from the starting one.
// - Write data is registered on pos and neg input clock rises.
// - Read data is launched on pos and neg input clock rises.
// - After power-up the device is deselected with read outputs undriven.
// - Narrow mode: select 0 covers bits 8:0, select 1 bits 17:9; high keeps contents.
// - Wide mode: selects 0 to 3 cover four 9-bit lanes; only low lanes written.
// - Byte selects are sampled with each data word and may differ between words.
// - All byte selects high for a word leaves memory unchanged for that word.
// - Latency pin low selects legacy mode with one cycle read latency.
// - A read after a write to the same location returns the newest written data.
// - Deselected read port finishes pending reads, then floats outputs after next rise.
// - Read valid flag rises half a cycle before the first valid read word.
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
module ddr_burst_sram_port_protocol (
	// Clock and reset
	input  wire logic                                    i_clk,
	input  wire logic                                    i_rst_n,
	// Input clock pair, sampled as ordinary inputs
	input  wire logic                                    i_in_clk_p,
	input  wire logic                                    i_in_clk_n,
	// Command pins
	input  wire logic                                    i_read_port_select_n,
	input  wire logic                                    i_write_port_select_n,
	input  wire logic [ddr_sram_pkg::ADDR_W-1:0]         i_addr,
	input  wire logic                                    i_latency_mode_pin,
	// Write data pins
	input  wire logic [ddr_sram_pkg::WORD_W-1:0]         i_wr_data,
	input  wire logic [ddr_sram_pkg::LANES_WORD-1:0]     i_byte_write_select_n,
	// Read data pins
	output logic [ddr_sram_pkg::WORD_W-1:0]              o_rd_data,
	output logic                                         o_rd_data_oe,
	output logic                                         o_read_valid_flag,
	// AXI4-Lite write address and data
	input  wire logic                                    i_awvalid,
	output logic                                         o_awready,
	input  wire logic [ddr_sram_pkg::AXI_ADDR_W-1:0]     i_awaddr,
	input  wire logic                                    i_wvalid,
	output logic                                         o_wready,
	input  wire logic [ddr_sram_pkg::AXI_DATA_W-1:0]     i_wdata,
	input  wire logic [3:0]                              i_wstrb,
	// AXI4-Lite write response
	output logic                                         o_bvalid,
	input  wire logic                                    i_bready,
	output logic [ddr_sram_pkg::RESP_W-1:0]              o_bresp,
	// AXI4-Lite read
	input  wire logic                                    i_arvalid,
	output logic                                         o_arready,
	input  wire logic [ddr_sram_pkg::AXI_ADDR_W-1:0]     i_araddr,
	output logic                                         o_rvalid,
	input  wire logic                                    i_rready,
	output logic [ddr_sram_pkg::AXI_DATA_W-1:0]          o_rdata,
	output logic [ddr_sram_pkg::RESP_W-1:0]              o_rresp
);
	import ddr_sram_pkg::*;

	// ------------------------------------------------------------
	// Input clock edge detection
	// ------------------------------------------------------------
	logic clk_p_q, clk_n_q;
	logic pos_rise, neg_rise;

	// Idle high: clocks parked high give no false edge
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			clk_p_q <= 1'b1;
			clk_n_q <= 1'b1;
		end else begin
			clk_p_q <= i_in_clk_p;
			clk_n_q <= i_in_clk_n;
		end
	end

	// No edges means no read or write port state changes
	always_comb begin
		pos_rise = i_in_clk_p & ~clk_p_q;
		neg_rise = i_in_clk_n & ~clk_n_q;
	end

	// ------------------------------------------------------------
	// Control register and helpers
	// ------------------------------------------------------------
	logic [31:0] ctrl_q, ctrl_d;
	logic        narrow;

	assign narrow = ctrl_q[CTRL_NARROW];

	function automatic logic [LANES_WORD-1:0] lanes_of(
		input logic [LANES_WORD-1:0] sel_n,
		input logic                  nar
	);
		logic [LANES_WORD-1:0] en;
		en = ~sel_n;
		if (nar) begin
			en[LANES_WORD-1:NARROW_LANES] = '0;
		end
		return en;
	endfunction

	function automatic logic [ADDR_W-1:0] addr_of(
		input logic [ADDR_W-1:0] a,
		input logic              nar
	);
		logic [ADDR_W-1:0] m;
		m = a;
		if (!nar) begin
			m[ADDR_W-1:WIDE_ADDR_W] = '0;
		end
		return m;
	endfunction

	// ------------------------------------------------------------
	// Write port
	// ------------------------------------------------------------
	wr_state_type           wr_state_q, wr_state_d;
	logic [WORD_W-1:0]      word0_q, word0_d;
	logic [LANES_WORD-1:0]  lane0_q, lane0_d;
	logic                   mem_we;
	logic [ADDR_W-1:0]      mem_waddr;
	logic [LANES_BURST-1:0] mem_lanes;
	logic [BURST_W-1:0]     mem_wdata;
	logic                   wr_start;

	always_comb begin
		wr_state_d = wr_state_q;
		word0_d    = word0_q;
		lane0_d    = lane0_q;
		mem_we     = 1'b0;
		mem_waddr  = addr_of(i_addr, narrow);
		mem_lanes  = {lanes_of(i_byte_write_select_n, narrow), lane0_q};
		mem_wdata  = {i_wr_data, word0_q};
		wr_start   = pos_rise & ~i_write_port_select_n;
		unique case (wr_state_q)
			WR_IDLE: begin
			end
			WR_ARMED: begin
				if (neg_rise) begin
					mem_we     = 1'b1;
					wr_state_d = WR_IDLE;
				end
			end
		endcase
		// Read select ignored: both may start together
		if (wr_start) begin
			word0_d    = i_wr_data;
			lane0_d    = lanes_of(i_byte_write_select_n, narrow);
			wr_state_d = WR_ARMED;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_state_q <= WR_IDLE;
			word0_q    <= '0;
			lane0_q    <= '0;
		end else begin
			wr_state_q <= wr_state_d;
			word0_q    <= word0_d;
			lane0_q    <= lane0_d;
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	logic [1:0]         rd_v_q, rd_v_d;
	logic [ADDR_W-1:0]  rd_a_q [2];
	logic [ADDR_W-1:0]  rd_a_d [2];
	logic               lat_full_q, lat_full_d;
	logic               launch;
	logic [ADDR_W-1:0]  launch_addr;
	logic [BURST_W-1:0] mem_rdata;
	logic [WORD_W-1:0]  word_mask;
	logic [WORD_W-1:0]  q_q, q_d;
	logic [WORD_W-1:0]  hold1_q, hold1_d;
	logic               oe_q, oe_d;
	logic               flag_q, flag_d;
	logic               rd_start;

	always_comb begin
		rd_start    = pos_rise & ~i_read_port_select_n;
		// Stage index is one less than the cycles since the command
		launch      = lat_full_q ? rd_v_q[READ_LAT_FULL-1] : rd_v_q[READ_LAT_LEGACY-1];
		launch_addr = lat_full_q ? rd_a_q[READ_LAT_FULL-1] : rd_a_q[READ_LAT_LEGACY-1];
		word_mask   = narrow ? WORD_W'({NARROW_LANES*LANE_W{1'b1}}) : '1;
		rd_v_d      = rd_v_q;
		rd_a_d      = rd_a_q;
		lat_full_d  = lat_full_q;
		q_d         = q_q;
		hold1_d     = hold1_q;
		oe_d        = oe_q;
		flag_d      = flag_q;
		if (pos_rise) begin
			rd_v_d     = {rd_v_q[0], rd_start};
			rd_a_d[0]  = addr_of(i_addr, narrow);
			rd_a_d[1]  = rd_a_q[0];
			lat_full_d = i_latency_mode_pin;
			oe_d       = launch;
			if (launch) begin
				// Launch-time array read sees all committed writes
				q_d     = mem_rdata[WORD_W-1:0] & word_mask;
				hold1_d = mem_rdata[BURST_W-1:WORD_W] & word_mask;
			end
		end
		if (neg_rise) begin
			// Flag leads the launched word by half a cycle
			flag_d = launch;
			if (oe_q) begin
				q_d = hold1_q;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_v_q     <= 2'h0;
			rd_a_q     <= '{default: '0};
			lat_full_q <= 1'b1;
			q_q        <= '0;
			hold1_q    <= '0;
			oe_q       <= 1'b0;
			flag_q     <= 1'b0;
		end else begin
			rd_v_q     <= rd_v_d;
			rd_a_q     <= rd_a_d;
			lat_full_q <= lat_full_d;
			q_q        <= q_d;
			hold1_q    <= hold1_d;
			oe_q       <= oe_d;
			flag_q     <= flag_d;
		end
	end

	assign o_rd_data         = q_q;
	assign o_rd_data_oe      = oe_q;
	assign o_read_valid_flag = flag_q;

	burst_array u_array (
		.i_clk        (i_clk),
		.i_wr_en      (mem_we),
		.i_wr_addr    (mem_waddr),
		.i_wr_lane_en (mem_lanes),
		.i_wr_data    (mem_wdata),
		.i_rd_addr    (launch_addr),
		.o_rd_data    (mem_rdata)
	);

	// ------------------------------------------------------------
	// Register bus: write side and counters
	// ------------------------------------------------------------
	logic                  aw_full_q, aw_full_d;
	logic [AXI_ADDR_W-1:0] aw_addr_q, aw_addr_d;
	logic                  w_full_q, w_full_d;
	logic [31:0]           w_data_q, w_data_d;
	logic [3:0]            w_strb_q, w_strb_d;
	logic                  bvalid_q, bvalid_d;
	logic [RESP_W-1:0]     bresp_q, bresp_d;
	logic [31:0]           rd_cnt_q, rd_cnt_d;
	logic [31:0]           wr_cnt_q, wr_cnt_d;
	logic                  clr_cnt;

	assign o_awready = ~aw_full_q & ~bvalid_q;
	assign o_wready  = ~w_full_q & ~bvalid_q;
	assign o_bvalid  = bvalid_q;
	assign o_bresp   = bresp_q;

	always_comb begin
		aw_full_d = aw_full_q;
		aw_addr_d = aw_addr_q;
		w_full_d  = w_full_q;
		w_data_d  = w_data_q;
		w_strb_d  = w_strb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		ctrl_d    = ctrl_q;
		clr_cnt   = 1'b0;
		if (i_awvalid && o_awready) begin
			aw_full_d = 1'b1;
			aw_addr_d = i_awaddr;
		end
		if (i_wvalid && o_wready) begin
			w_full_d = 1'b1;
			w_data_d = i_wdata;
			w_strb_d = i_wstrb;
		end
		if (aw_full_q && w_full_q && !bvalid_q) begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = RESP_OKAY;
			unique case (aw_addr_q)
				OFS_CTRL: begin
					if (w_strb_q[0]) begin
						ctrl_d[CTRL_NARROW] = w_data_q[CTRL_NARROW];
						clr_cnt             = w_data_q[CTRL_CLR_CNT];
					end
				end
				OFS_STATUS, OFS_RD_COUNT, OFS_WR_COUNT: begin
				end
				default: begin
					bresp_d = RESP_SLVERR;
				end
			endcase
		end else if (bvalid_q && i_bready) begin
			bvalid_d = 1'b0;
		end
		// Clear plus command counts one
		rd_cnt_d = (clr_cnt ? 32'h0000_0000 : rd_cnt_q) + {31'h0, rd_start};
		wr_cnt_d = (clr_cnt ? 32'h0000_0000 : wr_cnt_q) + {31'h0, wr_start};
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= '0;
			w_full_q  <= 1'b0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			ctrl_q    <= CTRL_RESET;
			rd_cnt_q  <= '0;
			wr_cnt_q  <= '0;
		end else begin
			aw_full_q <= aw_full_d;
			aw_addr_q <= aw_addr_d;
			w_full_q  <= w_full_d;
			w_data_q  <= w_data_d;
			w_strb_q  <= w_strb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			ctrl_q    <= ctrl_d;
			rd_cnt_q  <= rd_cnt_d;
			wr_cnt_q  <= wr_cnt_d;
		end
	end

	// ------------------------------------------------------------
	// Register bus: read side through the answer buffer
	// ------------------------------------------------------------
	logic [31:0]              ar_data;
	logic [RESP_W-1:0]        ar_resp;
	logic [RESP_W+31:0]       rbuf_out;

	always_comb begin
		ar_data = 32'h0000_0000;
		ar_resp = RESP_OKAY;
		unique case (i_araddr)
			OFS_CTRL: begin
				ar_data[CTRL_NARROW] = ctrl_q[CTRL_NARROW];
			end
			OFS_STATUS: begin
				ar_data[STAT_OE]       = oe_q;
				ar_data[STAT_VALID]    = flag_q;
				ar_data[STAT_LAT_FULL] = lat_full_q;
				ar_data[STAT_WR_ARMED] = (wr_state_q == WR_ARMED);
			end
			OFS_RD_COUNT: begin
				ar_data = rd_cnt_q;
			end
			OFS_WR_COUNT: begin
				ar_data = wr_cnt_q;
			end
			default: begin
				ar_resp = RESP_SLVERR;
			end
		endcase
	end

	// Full buffer refuses the address, so no answer is lost
	two_entry_buffer #(
		.WIDTH (RESP_W + 32)
	) u_rbuf (
		.i_clk       (i_clk),
		.i_rst_n     (i_rst_n),
		.i_in_valid  (i_arvalid),
		.o_in_ready  (o_arready),
		.i_in_data   ({ar_resp, ar_data}),
		.o_out_valid (o_rvalid),
		.i_out_ready (i_rready),
		.o_out_data  (rbuf_out)
	);

	assign o_rdata = rbuf_out[31:0];
	assign o_rresp = rbuf_out[RESP_W+31:32];

endmodule

/* ddr_sram_port_sva.sv */
// Pin-side timing checker for the burst SRAM port
`timescale 1ns/10ps
module ddr_sram_port_sva (
	// Clock and reset
	input wire logic                             i_clk,
	input wire logic                             i_rst_n,
	// Command pins
	input wire logic                             i_in_clk_p,
	input wire logic                             i_in_clk_n,
	input wire logic                             i_read_port_select_n,
	input wire logic                             i_latency_mode_pin,
	// Read pins
	input wire logic [ddr_sram_pkg::WORD_W-1:0] o_rd_data,
	input wire logic                             o_rd_data_oe,
	input wire logic                             o_read_valid_flag
);
	import ddr_sram_pkg::*;
	logic p_q, n_q, a1_q, l1_q, a2_q, l2_q;
	logic p_d, n_d, a1_d, l1_d, a2_d, l2_d;
	logic pos_rise, neg_rise, due;

	// ----------------------------------------
	// Edge detect and launch pipeline
	// ----------------------------------------
	always_comb begin
		pos_rise = i_in_clk_p && !p_q;
		neg_rise = i_in_clk_n && !n_q;
		due = (a1_q && !l1_q) || (a2_q && l2_q);
		{p_d, n_d} = {i_in_clk_p, i_in_clk_n};
		{a1_d, l1_d, a2_d, l2_d} = {a1_q, l1_q, a2_q, l2_q};
		if (pos_rise)
			{a1_d, l1_d, a2_d, l2_d} = {!i_read_port_select_n, i_latency_mode_pin, a1_q, l1_q};
	end

	// Detectors start high: no false rise
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			{p_q, n_q, a1_q, l1_q, a2_q, l2_q} <= 6'h30;
		else
			{p_q, n_q, a1_q, l1_q, a2_q, l2_q} <= {p_d, n_d, a1_d, l1_d, a2_d, l2_d};
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence launch_s; pos_rise && due; endsequence
	sequence flag_set_s; neg_rise && due; endsequence

	oe_launch_a: assert property (launch_s |=> o_rd_data_oe)
		else $error("no oe at launch");
	oe_float_a: assert property (pos_rise && !due |=> !o_rd_data_oe)
		else $error("oe without launch");
	oe_hold_a: assert property (!pos_rise |=> $stable(o_rd_data_oe))
		else $error("oe moved without pos rise");
	data_hold_a: assert property (!pos_rise && !neg_rise |=> $stable(o_rd_data))
		else $error("data moved without rise");
	flag_lead_a: assert property (flag_set_s |=> o_read_valid_flag)
		else $error("flag not raised ahead");
	flag_clear_a: assert property (neg_rise && !due |=> !o_read_valid_flag)
		else $error("flag without launch");
	flag_hold_a: assert property (!neg_rise |=> $stable(o_read_valid_flag))
		else $error("flag moved without neg rise");
	power_idle_a: assert property ($rose(i_rst_n) |-> !o_rd_data_oe && !o_read_valid_flag)
		else $error("outputs active after reset");
endmodule

bind ddr_burst_sram_port_protocol ddr_sram_port_sva chk (
	.i_clk, .i_rst_n, .i_in_clk_p, .i_in_clk_n, .i_read_port_select_n,
	.i_latency_mode_pin, .o_rd_data, .o_rd_data_oe, .o_read_valid_flag
);

/* mem_ctrl_model.sv */
// Controller model: input clocks, commands, write data
`timescale 1ns/10ps
module mem_ctrl_model (
	// Clock
	input wire logic                                 i_clk,
	// Input clock pair
	output logic                                     o_in_clk_p,
	output logic                                     o_in_clk_n,
	// Commands and write data
	output logic                                     o_read_port_select_n,
	output logic                                     o_write_port_select_n,
	output logic [ddr_sram_pkg::ADDR_W-1:0]          o_addr,
	output logic [ddr_sram_pkg::WORD_W-1:0]          o_wr_data,
	output logic [ddr_sram_pkg::LANES_WORD-1:0]      o_byte_write_select_n,
	// Mid-phase check point for the bench
	output logic                                     o_mid
);
	import ddr_sram_pkg::*;
	initial begin
		{o_in_clk_p, o_in_clk_n, o_read_port_select_n, o_write_port_select_n} = 4'hf;
		{o_addr, o_wr_data, o_mid} = '0;
		o_byte_write_select_n = '1;
	end

	// One clock phase of four system cycles
	task automatic half(input logic p, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d,
			input logic [LANES_WORD-1:0] b, input logic rs, input logic ws);
		o_in_clk_p <= p;
		o_in_clk_n <= !p;
		o_addr <= a;
		o_wr_data <= d;
		o_byte_write_select_n <= b;
		o_read_port_select_n <= rs;
		o_write_port_select_n <= ws;
		repeat (3) @(posedge i_clk);
		o_mid <= 1'b1;
		@(posedge i_clk);
		o_mid <= 1'b0;
	endtask

	// Idle address and write data lines show the inverse of their last value; byte selects are driven as given
	task automatic burst_cycle(input logic rd, input logic [ADDR_W-1:0] ra, input logic wr,
			input logic [ADDR_W-1:0] wa, input logic [WORD_W-1:0] d0, input logic [WORD_W-1:0] d1,
			input logic [LANES_WORD-1:0] b0, input logic [LANES_WORD-1:0] b1);
		if (o_in_clk_p) begin
			o_in_clk_p <= 1'b0;
			repeat (2) @(posedge i_clk);
		end
		half(1'b1, rd ? ra : ~o_addr, wr ? d0 : ~o_wr_data, b0, !rd, !wr);
		half(1'b0, wr ? wa : ~o_addr, wr ? d1 : ~o_wr_data, b1, 1'b1, 1'b1);
	endtask
endmodule

/* ddr_burst_sram_port_protocol_bench.sv */
// Self-checking bench for the burst SRAM port protocol block
`timescale 1ns/10ps
module ddr_burst_sram_port_protocol_bench;
	import ddr_sram_pkg::*;
	logic                   i_clk, i_rst_n, i_in_clk_p, i_in_clk_n, i_latency_mode_pin;
	logic                   i_read_port_select_n, i_write_port_select_n, o_rd_data_oe;
	logic                   o_read_valid_flag, i_awvalid, o_awready, i_wvalid, o_wready;
	logic                   o_bvalid, i_bready, i_arvalid, o_arready, o_rvalid, i_rready, mid;
	logic [ADDR_W-1:0]      i_addr, base;
	logic [WORD_W-1:0]      i_wr_data, o_rd_data;
	logic [LANES_WORD-1:0]  i_byte_write_select_n, i_wstrb;
	logic [AXI_ADDR_W-1:0]  i_awaddr, i_araddr;
	logic [AXI_DATA_W-1:0]  i_wdata, o_rdata;
	logic [RESP_W-1:0]      o_bresp, o_rresp;
	logic [BURST_W-1:0]     mem [8], wdat [512], burst;
	logic [LANES_BURST-1:0] wbn [512];
	bit                     rdue [512], wpend [512], nar;
	int                     rofs [512], wofs [512], fails, check_count, seed, ncyc, pcyc, nrd, nwr;

	ddr_burst_sram_port_protocol dut (
		.i_clk, .i_rst_n, .i_in_clk_p, .i_in_clk_n, .i_read_port_select_n,
		.i_write_port_select_n, .i_addr, .i_latency_mode_pin, .i_wr_data,
		.i_byte_write_select_n, .o_rd_data, .o_rd_data_oe, .o_read_valid_flag,
		.i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready, .i_wdata, .i_wstrb,
		.o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid,
		.i_rready, .o_rdata, .o_rresp
	);
	mem_ctrl_model ctl (
		.i_clk, .o_in_clk_p(i_in_clk_p), .o_in_clk_n(i_in_clk_n),
		.o_read_port_select_n(i_read_port_select_n), .o_addr(i_addr), .o_mid(mid),
		.o_write_port_select_n(i_write_port_select_n), .o_wr_data(i_wr_data),
		.o_byte_write_select_n(i_byte_write_select_n)
	);

	// ----------------------------------------
	// Expectations and checks
	// ----------------------------------------
	function automatic logic [BURST_W-1:0] merge(input logic [BURST_W-1:0] old,
			input logic [BURST_W-1:0] d, input logic [LANES_BURST-1:0] bn);
		for (int k = 0; k < LANES_BURST; k++)
			if (!bn[k] && !(nar && (k % LANES_WORD) >= NARROW_LANES))
				old[k*LANE_W +: LANE_W] = d[k*LANE_W +: LANE_W];
		return old;
	endfunction
	function automatic logic [WORD_W-1:0] word(input logic [BURST_W-1:0] b, input int h);
		word = b[h*WORD_W +: WORD_W];
		if (nar)
			word[WORD_W-1:NARROW_LANES*LANE_W] = '0;
	endfunction
	task automatic check(input logic [BURST_W-1:0] got, input logic [BURST_W-1:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		if (fails == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Model array follows the write's neg rise
	always @(negedge i_clk) begin
		if (mid === 1'b1 && i_in_clk_p === 1'b1) begin
			burst = mem[rofs[pcyc]];
			check(o_rd_data_oe, rdue[pcyc]);
			check(o_read_valid_flag, rdue[pcyc]);
			if (rdue[pcyc])
				check(o_rd_data, word(burst, 0));
		end
		if (mid === 1'b1 && i_in_clk_p === 1'b0) begin
			check(o_read_valid_flag, rdue[pcyc+1]);
			if (rdue[pcyc])
				check(o_rd_data, word(burst, 1));
			if (wpend[pcyc])
				mem[wofs[pcyc]] = merge(mem[wofs[pcyc]], wdat[pcyc], wbn[pcyc]);
			pcyc++;
		end
	end

	// ----------------------------------------
	// Pin and bus drivers
	// ----------------------------------------
	task automatic op(input bit rd, input bit wr, input int ri, input int wi,
			input logic [BURST_W-1:0] d, input logic [LANES_BURST-1:0] bn);
		int t;
		t = ncyc + (i_latency_mode_pin ? READ_LAT_FULL : READ_LAT_LEGACY);
		if (rd)
			{rdue[t], rofs[t]} = {1'b1, ri};
		{wpend[ncyc], wofs[ncyc], wdat[ncyc], wbn[ncyc]} = {wr, wi, d, bn};
		nrd += rd;
		nwr += wr;
		ncyc++;
		ctl.burst_cycle(rd, ADDR_W'(base + ri), wr, ADDR_W'(base + wi), d[WORD_W-1:0],
			d[BURST_W-1:WORD_W], bn[3:0], bn[7:4]);
	endtask
	task automatic traffic(input int n);
		logic [31:0] r;
		repeat (n) begin
			r = $random(seed);
			op(r[0], r[1], r[4:2], r[7:5], BURST_W'({$random(seed), $random(seed), $random(seed)}),
				r[9:8] == 2'h0 ? 8'h00 : (r[9:8] == 2'h1 ? 8'hf0 : r[23:16]));
		end
		repeat (4) op(0, 0, 0, 0, '0, '1);
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		bit aw_ok, w_ok;
		@(posedge i_clk);
		{i_awvalid, i_wvalid, i_bready, i_awaddr, i_wdata} <= {3'b111, a, d};
		while (!(aw_ok && w_ok)) begin
			@(posedge i_clk);
			aw_ok = aw_ok || o_awready === 1'b1;
			w_ok = w_ok || o_wready === 1'b1;
			{i_awvalid, i_wvalid} <= {!aw_ok, !w_ok};
		end
		while (o_bvalid !== 1'b1)
			@(posedge i_clk);
		i_bready <= 1'b0;
		check(o_bresp, er);
	endtask
	task automatic ar_issue(input logic [7:0] a);
		@(posedge i_clk);
		{i_arvalid, i_araddr} <= {1'b1, a};
		do
			@(posedge i_clk);
		while (o_arready !== 1'b1);
		i_arvalid <= 1'b0;
	endtask
	task automatic r_take(input logic [31:0] ed, input logic [1:0] er);
		@(posedge i_clk);
		i_rready <= 1'b1;
		do
			@(posedge i_clk);
		while (o_rvalid !== 1'b1);
		i_rready <= 1'b0;
		check({o_rresp, o_rdata}, {er, ed});
	endtask

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	initial begin
		#200000;
		fails++;
		end_of_test;
	end
	initial begin
		seed = 32'h1fb1;
		{i_rst_n, i_latency_mode_pin, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 7'h20;
		{i_awaddr, i_araddr, i_wdata, i_wstrb} = {16'h0, 32'h0, 4'hf};
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		check({o_rd_data_oe, o_read_valid_flag}, 2'b00);
		base = ADDR_W'($random(seed)) & 22'h1ffff8;
		for (int i = 0; i < 8; i++)
			op(0, 1, 0, i, BURST_W'({$random(seed), $random(seed), $random(seed)}), 8'h00);
		traffic(60);
		i_latency_mode_pin <= 1'b0;
		traffic(30);
		i_latency_mode_pin <= 1'b1;
		axi_wr(OFS_CTRL, 32'h1, RESP_OKAY);
		nar = 1'b1;
		ar_issue(OFS_CTRL);
		r_take(32'h1, RESP_OKAY);
		traffic(20);
		axi_wr(OFS_CTRL, 32'h0, RESP_OKAY);
		nar = 1'b0;
		repeat (20) @(posedge i_clk);
		ar_issue(OFS_RD_COUNT);
		r_take(nrd, RESP_OKAY);
		ar_issue(OFS_WR_COUNT);
		r_take(nwr, RESP_OKAY);
		axi_wr(OFS_STATUS, 32'hf, RESP_OKAY);
		ar_issue(OFS_STATUS);
		r_take(32'h4, RESP_OKAY);
		axi_wr(8'h10, 32'h1, RESP_SLVERR);
		ar_issue(8'h10);
		r_take(32'h0, RESP_SLVERR);
		axi_wr(OFS_CTRL, 32'h3, RESP_OKAY);
		ar_issue(OFS_CTRL);
		ar_issue(OFS_RD_COUNT);
		@(negedge i_clk);
		check(o_arready, 1'b0);
		r_take(32'h1, RESP_OKAY);
		r_take(32'h0, RESP_OKAY);
		end_of_test;
	end
endmodule
